// ---- hdl/stop_wait_regs.svh ----
`ifndef STOP_WAIT_REGS_SVH
`define STOP_WAIT_REGS_SVH

// =====================================================================
// Wait timer preset values
`define TIMER3_PRESET      8'hff
`define TIMER4_PRESET      8'h07

// =====================================================================
// Count source prescaler
`define PRESCALE_BITS      4
`define PRESCALE_LAST      4'hf

// =====================================================================
// Timing
`define CLK_PERIOD_NS      40
`define RESET_MIN_NS       2000
`define RESET_MIN_CYCLES   ((`RESET_MIN_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define RESET_CNT_BITS     6

`endif

// ---- hdl/stop_wait_pkg.sv ----
`include "stop_wait_regs.svh"

package stop_wait_pkg;

	// =====================================================================
	// Sequencer states, Gray coded along power-on -> run -> stop -> wake; wake -> run changes two bits
	typedef enum logic [2:0] {
		ST_INIT_WAIT = 3'h0,
		ST_RUN       = 3'h1,
		ST_STOP      = 3'h3,
		ST_WAKE_WAIT = 3'h2,
		ST_PIN_RESET = 3'h4
	} seq_state_t;

	// =====================================================================
	// Timer three count source
	typedef enum logic [1:0] {
		SRC_MAIN_DIV16 = 2'h0,
		SRC_SUB_DIV16  = 2'h1,
		SRC_MAIN_DIV2  = 2'h2,
		SRC_SUB_DIV2   = 2'h3
	} count_src_t;

	// =====================================================================
	// Wake-up request lines
	typedef enum int {
		WK_EXT0   = 0,
		WK_EXT1   = 1,
		WK_COUNTER_PIN_INTERRUPT_ZERO  = 2,
		WK_COUNTER_PIN_INTERRUPT_ONE  = 3,
		WK_SERIAL = 4,
		WK_TIMER1 = 5,
		WK_TIMER2 = 6,
		WK_KEY    = 7
	} wake_src_t;

	localparam int WAKE_LINES = 8;

endpackage : stop_wait_pkg

// ---- hdl/wait_timer.sv ----
`timescale 1ns/1ps

module wait_timer #(
	parameter int               WIDTH       = 8,
	parameter logic [WIDTH-1:0] RESET_VALUE = '1
) (
	input  wire logic             CLK,
	input  wire logic             NRST,
	input  wire logic             load,
	input  wire logic [WIDTH-1:0] load_value,
	input  wire logic             count_pulse,
	output logic      [WIDTH-1:0] count,
	output logic                  underflow
);

	typedef struct packed {
		logic [WIDTH-1:0] count;
		logic [WIDTH-1:0] latch;
		logic             underflow;
	} timer_reg_t;

	localparam timer_reg_t TIMER_RESET = '{count: RESET_VALUE, latch: RESET_VALUE, underflow: 1'b0};

	timer_reg_t timer_reg;
	timer_reg_t timer_next;

	// =====================================================================
	// Down counter with reload latch
	always_comb begin
		timer_next           = timer_reg;
		timer_next.underflow = 1'b0;
		if (load) begin
			timer_next.count = load_value;
			timer_next.latch = load_value;
		end else if (count_pulse) begin
			if (timer_reg.count == '0) begin
				timer_next.count     = timer_reg.latch;
				timer_next.underflow = 1'b1;
			end else begin
				timer_next.count = timer_reg.count - 1'b1;
			end
		end
	end

	always_ff @(posedge CLK or negedge NRST) begin
		if (!NRST) begin
			timer_reg <= TIMER_RESET;
		end else begin
			timer_reg <= timer_next;
		end
	end

	assign count     = timer_reg.count;
	assign underflow = timer_reg.underflow;

endmodule : wait_timer

// ---- hdl/stop_mode_oscillation_wait_control.sv ----
`timescale 1ns/1ps
`include "stop_wait_regs.svh"

module stop_mode_oscillation_wait_control
	import stop_wait_pkg::*;
(
	input  wire logic                  CLK,
	input  wire logic                  NRST,
	input  wire logic                  RESET_PIN_N,
	input  wire logic                  MAIN_OSCILLATOR_INPUT,
	input  wire logic                  SUB_OSCILLATOR_INPUT,
	input  wire logic                  HALT_OSCILLATORS_INSTRUCTION,
	input  wire logic                  LOW_SPEED_SELECT,
	input  wire logic                  MAIN_OSC_STOP_SELECT,
	input  wire logic                  SUB_OSC_ENABLE,
	input  wire logic                  SUB_DRIVE_HIGH_SELECT,
	input  wire logic [1:0]            TIMER3_SOURCE_SELECT,
	input  wire logic                  TIMER3_COUNT_STOP,
	input  wire logic                  TIMER4_COUNT_STOP,
	input  wire logic [WAKE_LINES-1:0] WAKE_REQUEST,
	input  wire logic [WAKE_LINES-1:0] WAKE_ENABLE,
	input  wire logic                  SERIAL_EXT_CLOCK,
	input  wire logic                  TIMER1_EXT_CLOCK,
	input  wire logic                  TIMER2_EXT_CLOCK,
	input  wire logic                  TIMER3_FLAG_CLEAR,
	input  wire logic                  TIMER4_FLAG_CLEAR,
	output logic                       MAIN_OSC_RUN,
	output logic                       SUB_OSC_RUN,
	output logic                       SUB_OSCILLATOR_DRIVE_PIN,
	output logic                       SYSTEM_CLOCK_TICK,
	output logic                       CPU_CLOCK_ENABLE,
	output logic                       CPU_RESET_N,
	output logic                       STOP_MODE,
	output logic                       STATE_HOLD,
	output logic                       INTERNAL_TIMER_HALT,
	output logic                       TIMER1_HALT,
	output logic                       TIMER2_HALT,
	output logic                       SERIAL_HALT,
	output logic                       CONVERSION_HALT,
	output logic                       WAKE_ACCEPTED,
	output logic                       SUB_OSC_SETTLED,
	output logic                       TIMER3_FLAG,
	output logic                       TIMER4_FLAG,
	output logic [7:0]                 TIMER3_VALUE,
	output logic [7:0]                 TIMER4_VALUE
);

	// =====================================================================
	// State
	typedef struct packed {
		seq_state_t                 state;
		logic                       main_sync1;
		logic                       main_sync2;
		logic                       main_prev;
		logic                       sub_sync1;
		logic                       sub_sync2;
		logic                       sub_prev;
		logic                       rst_sync1;
		logic                       rst_sync2;
		logic [`RESET_CNT_BITS-1:0] rst_low_cnt;
		logic [`PRESCALE_BITS-1:0]  main_div;
		logic [`PRESCALE_BITS-1:0]  sub_div;
		logic                       phi_div;
		logic                       phi_tick;
		count_src_t                 src_snap;
		logic                       low_speed_snap;
		logic                       main_stop_snap;
		logic                       sub_en_snap;
		logic                       drive_snap;
		logic                       main_run;
		logic                       sub_run;
		logic                       drive_high;
		logic                       t3_flag;
		logic                       t4_flag;
		logic                       sub_settled;
		logic                       wake_pulse;
	} seq_reg_t;

	// Power-on starts in the wait with only the main oscillator running
	localparam seq_reg_t SEQ_RESET = '{
		state:    ST_INIT_WAIT,
		src_snap: SRC_MAIN_DIV16,
		main_run: 1'b1,
		default:  '0
	};

	localparam logic [`RESET_CNT_BITS-1:0] RESET_MIN = `RESET_CNT_BITS'(`RESET_MIN_CYCLES);

	seq_reg_t seq_reg;
	seq_reg_t seq_next;

	logic       main_edge;
	logic       sub_edge;
	logic       main_div16;
	logic       sub_div16;
	logic       phi_edge;
	logic       waiting;
	logic       reset_seen;
	logic       wake;
	logic       t3_load;
	logic       t3_pulse;
	logic       t4_pulse;
	logic       t3_uf;
	logic       t4_uf;
	logic [7:0] t3_count;
	logic [7:0] t4_count;
	count_src_t active_src;
	logic [WAKE_LINES-1:0] wake_eligible;

	// =====================================================================
	// Helpers
	function automatic logic source_pulse(
		input count_src_t src,
		input logic       m16,
		input logic       s16,
		input logic       m2,
		input logic       s2
	);
		case (src)
			SRC_MAIN_DIV16: source_pulse = m16;
			SRC_SUB_DIV16:  source_pulse = s16;
			SRC_MAIN_DIV2:  source_pulse = m2;
			SRC_SUB_DIV2:   source_pulse = s2;
			default:        source_pulse = 1'b0;
		endcase
	endfunction : source_pulse

	function automatic logic is_sub_source(input count_src_t src);
		is_sub_source = (src == SRC_SUB_DIV16) || (src == SRC_SUB_DIV2);
	endfunction : is_sub_source

	// =====================================================================
	// Cascaded wait timers
	wait_timer #(
		.WIDTH       (8),
		.RESET_VALUE (`TIMER3_PRESET)
	) u_timer3 (
		.CLK         (CLK),
		.NRST        (NRST),
		.load        (t3_load),
		.load_value  (`TIMER3_PRESET),
		.count_pulse (t3_pulse),
		.count       (t3_count),
		.underflow   (t3_uf)
	);

	wait_timer #(
		.WIDTH       (8),
		.RESET_VALUE (`TIMER4_PRESET)
	) u_timer4 (
		.CLK         (CLK),
		.NRST        (NRST),
		.load        (t3_load),
		.load_value  (`TIMER4_PRESET),
		.count_pulse (t4_pulse),
		.count       (t4_count),
		.underflow   (t4_uf)
	);

	// =====================================================================
	// Count events and system clock
	always_comb begin
		// Edges counted only while the oscillator is enabled, so a floating pin in stop adds nothing
		main_edge  = seq_reg.main_sync2 && !seq_reg.main_prev && seq_reg.main_run;
		sub_edge   = seq_reg.sub_sync2 && !seq_reg.sub_prev && seq_reg.sub_run;
		main_div16 = main_edge && (seq_reg.main_div == `PRESCALE_LAST);
		sub_div16  = sub_edge && (seq_reg.sub_div == `PRESCALE_LAST);
		phi_edge   = seq_reg.low_speed_snap ? sub_edge : main_edge;
		waiting    = (seq_reg.state == ST_INIT_WAIT) || (seq_reg.state == ST_WAKE_WAIT);
		case (seq_reg.state)
			ST_INIT_WAIT: active_src = SRC_MAIN_DIV16;
			ST_WAKE_WAIT: active_src = seq_reg.src_snap;
			default:      active_src = count_src_t'(TIMER3_SOURCE_SELECT);
		endcase
		// Feed timer three from the divided source; the prescalers keep their count across stop, so the first pulse needs up to 2 or 16 edges
		t3_pulse = source_pulse(active_src, main_div16, sub_div16,
			main_edge && seq_reg.main_div[0], sub_edge && seq_reg.sub_div[0]) &&
			(waiting || ((seq_reg.state == ST_RUN) && !TIMER3_COUNT_STOP));
		t4_pulse = t3_uf && (waiting || ((seq_reg.state == ST_RUN) && !TIMER4_COUNT_STOP));
	end

	// =====================================================================
	// Wake and reset detection
	always_comb begin
		wake_eligible            = '0;
		wake_eligible[WK_EXT0]   = 1'b1;
		wake_eligible[WK_EXT1]   = 1'b1;
		wake_eligible[WK_COUNTER_PIN_INTERRUPT_ZERO]  = 1'b1;
		wake_eligible[WK_COUNTER_PIN_INTERRUPT_ONE]  = 1'b1;
		wake_eligible[WK_SERIAL] = SERIAL_EXT_CLOCK;
		wake_eligible[WK_TIMER1] = TIMER1_EXT_CLOCK;
		wake_eligible[WK_TIMER2] = TIMER2_EXT_CLOCK;
		wake_eligible[WK_KEY]    = 1'b1;
		wake       = |(WAKE_REQUEST & WAKE_ENABLE & wake_eligible);
		// A short glitch on the pin is ignored; only a low of the least width resets
		reset_seen = !seq_reg.rst_sync2 && (seq_reg.rst_low_cnt >= (RESET_MIN - 1'b1));
		t3_load    = (reset_seen && (seq_reg.state != ST_PIN_RESET)) ||
			((seq_reg.state == ST_RUN) && HALT_OSCILLATORS_INSTRUCTION);
	end

	// =====================================================================
	// Sequencer
	always_comb begin
		seq_next            = seq_reg;
		seq_next.wake_pulse = 1'b0;
		seq_next.main_sync1 = MAIN_OSCILLATOR_INPUT;
		seq_next.main_sync2 = seq_reg.main_sync1;
		seq_next.main_prev  = seq_reg.main_sync2;
		seq_next.sub_sync1  = SUB_OSCILLATOR_INPUT;
		seq_next.sub_sync2  = seq_reg.sub_sync1;
		seq_next.sub_prev   = seq_reg.sub_sync2;
		seq_next.rst_sync1  = RESET_PIN_N;
		seq_next.rst_sync2  = seq_reg.rst_sync1;
		if (seq_reg.rst_sync2) begin
			seq_next.rst_low_cnt = '0;
		end else if (seq_reg.rst_low_cnt != RESET_MIN) begin
			seq_next.rst_low_cnt = seq_reg.rst_low_cnt + 1'b1;
		end
		seq_next.main_div = seq_reg.main_div + `PRESCALE_BITS'(main_edge);
		seq_next.sub_div  = seq_reg.sub_div + `PRESCALE_BITS'(sub_edge);
		seq_next.phi_div  = seq_reg.phi_div ^ phi_edge;
		seq_next.phi_tick = phi_edge && seq_reg.phi_div && (seq_reg.state == ST_RUN);
		// Hardware set wins over a software clear
		if (TIMER3_FLAG_CLEAR) begin
			seq_next.t3_flag = 1'b0;
		end
		if (TIMER4_FLAG_CLEAR) begin
			seq_next.t4_flag = 1'b0;
		end
		if (t3_uf) begin
			seq_next.t3_flag = 1'b1;
		end
		if (t4_uf) begin
			seq_next.t4_flag = 1'b1;
		end

		case (seq_reg.state)
			ST_INIT_WAIT: begin
				if (t4_uf) begin
					seq_next.state   = ST_RUN;
					seq_next.t3_flag = 1'b1;
					seq_next.t4_flag = 1'b1;
				end
			end
			ST_RUN: begin
				if (HALT_OSCILLATORS_INSTRUCTION) begin
					seq_next.state          = ST_STOP;
					seq_next.src_snap       = count_src_t'(TIMER3_SOURCE_SELECT);
					seq_next.low_speed_snap = LOW_SPEED_SELECT;
					seq_next.main_stop_snap = MAIN_OSC_STOP_SELECT;
					seq_next.sub_en_snap    = SUB_OSC_ENABLE;
					seq_next.drive_snap     = SUB_DRIVE_HIGH_SELECT;
					seq_next.sub_settled    = 1'b0;
				end else begin
					seq_next.low_speed_snap = LOW_SPEED_SELECT;
				end
			end
			ST_STOP: begin
				if (wake) begin
					seq_next.state      = ST_WAKE_WAIT;
					seq_next.wake_pulse = 1'b1;
				end
			end
			ST_WAKE_WAIT: begin
				if (t4_uf) begin
					seq_next.state       = ST_RUN;
					seq_next.t3_flag     = 1'b1;
					seq_next.t4_flag     = 1'b1;
					// Only a wait counted on the sub side says anything about the sub oscillator
					seq_next.sub_settled = is_sub_source(seq_reg.src_snap);
				end
			end
			ST_PIN_RESET: begin
				if (seq_reg.rst_sync2) begin
					seq_next.state = ST_INIT_WAIT;
				end
			end
			default: begin
				seq_next.state = ST_INIT_WAIT;
			end
		endcase

		// External reset overrides every state, stop included
		if (reset_seen) begin
			seq_next.state          = ST_PIN_RESET;
			seq_next.low_speed_snap = 1'b0;
			seq_next.sub_settled    = 1'b0;
			seq_next.t3_flag        = 1'b0;
			seq_next.t4_flag        = 1'b0;
		end

		case (seq_next.state)
			ST_RUN: begin
				seq_next.main_run   = !MAIN_OSC_STOP_SELECT;
				seq_next.sub_run    = SUB_OSC_ENABLE;
				seq_next.drive_high = SUB_DRIVE_HIGH_SELECT;
			end
			ST_WAKE_WAIT: begin
				seq_next.main_run   = !seq_reg.main_stop_snap;
				seq_next.sub_run    = seq_reg.sub_en_snap;
				seq_next.drive_high = seq_reg.drive_snap;
			end
			ST_STOP: begin
				seq_next.main_run   = 1'b0;
				seq_next.sub_run    = 1'b0;
				seq_next.drive_high = seq_reg.drive_snap;
			end
			default: begin
				seq_next.main_run   = 1'b1;
				seq_next.sub_run    = 1'b0;
				seq_next.drive_high = 1'b0;
			end
		endcase
	end

	always_ff @(posedge CLK or negedge NRST) begin
		if (!NRST) begin
			seq_reg <= SEQ_RESET;
		end else begin
			seq_reg <= seq_next;
		end
	end

	// =====================================================================
	// Outputs
	always_ff @(posedge CLK or negedge NRST) begin
		if (!NRST) begin
			CPU_CLOCK_ENABLE    <= 1'b0;
			CPU_RESET_N         <= 1'b0;
			STOP_MODE           <= 1'b0;
			STATE_HOLD          <= 1'b0;
			INTERNAL_TIMER_HALT <= 1'b0;
			TIMER1_HALT         <= 1'b0;
			TIMER2_HALT         <= 1'b0;
			SERIAL_HALT         <= 1'b0;
			CONVERSION_HALT     <= 1'b0;
		end else begin
			CPU_CLOCK_ENABLE    <= (seq_next.state == ST_RUN);
			CPU_RESET_N         <= (seq_next.state != ST_INIT_WAIT) && (seq_next.state != ST_PIN_RESET);
			STOP_MODE           <= (seq_next.state == ST_STOP);
			// Freeze covers the wake wait too, so held state stays put until the CPU clock returns; the timer, serial and conversion halts end with stop
			STATE_HOLD          <= (seq_next.state == ST_STOP) || (seq_next.state == ST_WAKE_WAIT);
			INTERNAL_TIMER_HALT <= (seq_next.state == ST_STOP);
			TIMER1_HALT         <= (seq_next.state == ST_STOP) && !TIMER1_EXT_CLOCK;
			TIMER2_HALT         <= (seq_next.state == ST_STOP) && !TIMER2_EXT_CLOCK;
			SERIAL_HALT         <= (seq_next.state == ST_STOP) && !SERIAL_EXT_CLOCK;
			CONVERSION_HALT     <= (seq_next.state == ST_STOP);
		end
	end

	assign MAIN_OSC_RUN             = seq_reg.main_run;
	assign SUB_OSC_RUN              = seq_reg.sub_run;
	assign SUB_OSCILLATOR_DRIVE_PIN = seq_reg.drive_high;
	assign SYSTEM_CLOCK_TICK        = seq_reg.phi_tick;
	assign WAKE_ACCEPTED            = seq_reg.wake_pulse;
	assign SUB_OSC_SETTLED          = seq_reg.sub_settled;
	assign TIMER3_FLAG              = seq_reg.t3_flag;
	assign TIMER4_FLAG              = seq_reg.t4_flag;
	assign TIMER3_VALUE             = t3_count;
	assign TIMER4_VALUE             = t4_count;

endmodule : stop_mode_oscillation_wait_control

// ---- sim/stop_wait_props.sv ----
`timescale 1ns/1ps
module stop_wait_props (
	input logic       CLK,
	input logic       NRST,
	input logic       RESET_PIN_N,
	input logic       HALT_OSCILLATORS_INSTRUCTION,
	input logic [7:0] WAKE_REQUEST,
	input logic [7:0] WAKE_ENABLE,
	input logic       SERIAL_EXT_CLOCK,
	input logic       TIMER1_EXT_CLOCK,
	input logic       TIMER2_EXT_CLOCK,
	input logic       MAIN_OSC_RUN,
	input logic       SUB_OSC_RUN,
	input logic       CPU_CLOCK_ENABLE,
	input logic       CPU_RESET_N,
	input logic       STOP_MODE,
	input logic       STATE_HOLD,
	input logic       INTERNAL_TIMER_HALT,
	input logic       SERIAL_HALT,
	input logic       CONVERSION_HALT,
	input logic       WAKE_ACCEPTED,
	input logic       TIMER3_FLAG,
	input logic       TIMER4_FLAG,
	input logic [7:0] TIMER3_VALUE,
	input logic [7:0] TIMER4_VALUE
);
	logic pre_main_reg;
	logic pre_sub_reg;
	wire  take = CPU_CLOCK_ENABLE && HALT_OSCILLATORS_INSTRUCTION;
	wire  elig = |(WAKE_REQUEST & WAKE_ENABLE & {1'b1, TIMER2_EXT_CLOCK, TIMER1_EXT_CLOCK, SERIAL_EXT_CLOCK, 4'hf});
	// =====================================================
	// Oscillator snapshot at the stop instruction
	always_ff @(posedge CLK or negedge NRST) begin
		if (!NRST) begin
			pre_main_reg <= 1'b1;
			pre_sub_reg <= 1'b0;
		end else if (take) begin
			pre_main_reg <= MAIN_OSC_RUN;
			pre_sub_reg <= SUB_OSC_RUN;
		end
	end
	default clocking @(posedge CLK); endclocking
	default disable iff (!NRST);
	// =====================================================
	// Properties
	chk_stop_entry: assert property (take |=> STOP_MODE && !CPU_CLOCK_ENABLE && !MAIN_OSC_RUN && !SUB_OSC_RUN)
		else $error("stop entry wrong");
	chk_timer_preset: assert property (take |=> TIMER3_VALUE == 8'hff && TIMER4_VALUE == 8'h07)
		else $error("timer preset wrong");
	chk_stop_hold: assert property (STOP_MODE |-> STATE_HOLD && INTERNAL_TIMER_HALT && CONVERSION_HALT)
		else $error("stop hold missing");
	chk_serial_halt: assert property (STOP_MODE && $stable(SERIAL_EXT_CLOCK) |-> SERIAL_HALT == !SERIAL_EXT_CLOCK)
		else $error("serial halt wrong");
	// Pin must be high two samples back, since a long low may end stop
	chk_wake_block: assert property (STOP_MODE && !elig && RESET_PIN_N && $past(RESET_PIN_N, 2) |=> STOP_MODE)
		else $error("stop left without cause");
	chk_wake_taken: assert property (STOP_MODE && elig |=> WAKE_ACCEPTED && !STOP_MODE)
		else $error("wake not taken");
	chk_wake_pulse: assert property (WAKE_ACCEPTED |-> CPU_RESET_N && !CPU_CLOCK_ENABLE ##1 !WAKE_ACCEPTED)
		else $error("wake pulse wrong");
	chk_osc_restore: assert property (WAKE_ACCEPTED |-> MAIN_OSC_RUN == pre_main_reg && SUB_OSC_RUN == pre_sub_reg)
		else $error("oscillators not restored");
	chk_run_flags: assert property ($rose(CPU_CLOCK_ENABLE) |-> TIMER3_FLAG && TIMER4_FLAG && !STATE_HOLD)
		else $error("flags not set at run");
	chk_reset_gate: assert property (!CPU_RESET_N |-> !CPU_CLOCK_ENABLE && !STOP_MODE)
		else $error("cpu runs in reset");
	cov_stop: cover property (take);
	cov_wake: cover property (WAKE_ACCEPTED);
	cov_pin: cover property ($fell(CPU_RESET_N));
endmodule : stop_wait_props

bind stop_mode_oscillation_wait_control stop_wait_props stop_wait_props_i (
	.CLK(CLK), .NRST(NRST), .RESET_PIN_N(RESET_PIN_N), .HALT_OSCILLATORS_INSTRUCTION(HALT_OSCILLATORS_INSTRUCTION),
	.WAKE_REQUEST(WAKE_REQUEST), .WAKE_ENABLE(WAKE_ENABLE), .SERIAL_EXT_CLOCK(SERIAL_EXT_CLOCK),
	.TIMER1_EXT_CLOCK(TIMER1_EXT_CLOCK), .TIMER2_EXT_CLOCK(TIMER2_EXT_CLOCK), .MAIN_OSC_RUN(MAIN_OSC_RUN),
	.SUB_OSC_RUN(SUB_OSC_RUN), .CPU_CLOCK_ENABLE(CPU_CLOCK_ENABLE), .CPU_RESET_N(CPU_RESET_N),
	.STOP_MODE(STOP_MODE), .STATE_HOLD(STATE_HOLD), .INTERNAL_TIMER_HALT(INTERNAL_TIMER_HALT),
	.SERIAL_HALT(SERIAL_HALT), .CONVERSION_HALT(CONVERSION_HALT), .WAKE_ACCEPTED(WAKE_ACCEPTED),
	.TIMER3_FLAG(TIMER3_FLAG), .TIMER4_FLAG(TIMER4_FLAG), .TIMER3_VALUE(TIMER3_VALUE), .TIMER4_VALUE(TIMER4_VALUE)
);

// ---- sim/far_side_model.sv ----
`timescale 1ns/1ps
module far_side_model (
	input  logic       clk,
	input  logic       main_run,
	input  logic       sub_run,
	input  logic       ack,
	output logic       main_in,
	output logic       sub_in,
	output logic       pin_n,
	output logic [7:0] req
);
	initial begin
		main_in = 1'b0;
		sub_in = 1'b0;
		pin_n = 1'b1;
		req = 8'h00;
	end
	// =====================================================
	// Oscillators stand still while disabled, phase unrelated to clk
	always #41 if (main_run) main_in = !main_in;
	always #43 if (sub_run) sub_in = !sub_in;
	// =====================================================
	// Requesters hold their line until the wake is served
	always @(negedge clk) if (ack) req = 8'h00;
	task automatic raise(input int line);
		@(negedge clk);
		req[line] = 1'b1;
	endtask : raise
	task automatic pin_reset(input int n);
		@(negedge clk);
		pin_n = 1'b0;
		repeat (n) @(negedge clk);
		pin_n = 1'b1;
	endtask : pin_reset
endmodule : far_side_model

// ---- sim/testbench.sv ----
`timescale 1ns/1ps
module testbench;
	logic        clk = 1'b0;
	logic        nrst = 1'b0;
	logic        halt = 1'b0;
	logic        sub_en = 1'b0;
	logic        drive_hi = 1'b0;
	logic        t_stop = 1'b0;
	logic        fclr = 1'b0;
	logic        ext_ser = 1'b0;
	logic        ext_tmr = 1'b1;
	logic [1:0]  src = 2'h0;
	logic [7:0]  wen = 8'h00;
	logic [31:0] seed = 32'h0000de97;
	logic        main_in, sub_in, pin_n, main_run, sub_run, cpu_en, cpu_rst_n, stop_m, hold, tmr_halt;
	logic        ser_halt, conv_halt, wake_ack, sub_ok, flag3, flag4, drv, tick, t1h, t2h;
	logic [7:0]  req, t3v, t4v;
	int          num_errors = 0;
	int          tests_run = 0;
	int          cycles = 0;
	int          me = 0;
	int          se = 0;
	int          tk = 0;
	int          line, n;

	stop_mode_oscillation_wait_control stop_mode_oscillation_wait_control_i (
		.CLK(clk), .NRST(nrst), .RESET_PIN_N(pin_n), .MAIN_OSCILLATOR_INPUT(main_in), .SUB_OSCILLATOR_INPUT(sub_in),
		.HALT_OSCILLATORS_INSTRUCTION(halt), .LOW_SPEED_SELECT(1'b0), .MAIN_OSC_STOP_SELECT(1'b0),
		.SUB_OSC_ENABLE(sub_en), .SUB_DRIVE_HIGH_SELECT(drive_hi), .TIMER3_SOURCE_SELECT(src),
		.TIMER3_COUNT_STOP(t_stop), .TIMER4_COUNT_STOP(t_stop), .WAKE_REQUEST(req), .WAKE_ENABLE(wen),
		.SERIAL_EXT_CLOCK(ext_ser), .TIMER1_EXT_CLOCK(ext_tmr), .TIMER2_EXT_CLOCK(ext_tmr),
		.TIMER3_FLAG_CLEAR(fclr), .TIMER4_FLAG_CLEAR(fclr), .MAIN_OSC_RUN(main_run), .SUB_OSC_RUN(sub_run),
		.SUB_OSCILLATOR_DRIVE_PIN(drv), .SYSTEM_CLOCK_TICK(tick), .CPU_CLOCK_ENABLE(cpu_en),
		.CPU_RESET_N(cpu_rst_n), .STOP_MODE(stop_m), .STATE_HOLD(hold), .INTERNAL_TIMER_HALT(tmr_halt),
		.TIMER1_HALT(t1h), .TIMER2_HALT(t2h),
		.SERIAL_HALT(ser_halt), .CONVERSION_HALT(conv_halt), .WAKE_ACCEPTED(wake_ack), .SUB_OSC_SETTLED(sub_ok),
		.TIMER3_FLAG(flag3), .TIMER4_FLAG(flag4), .TIMER3_VALUE(t3v), .TIMER4_VALUE(t4v)
	);
	far_side_model far_side_model_i (
		.clk(clk), .main_run(main_run), .sub_run(sub_run), .ack(wake_ack),
		.main_in(main_in), .sub_in(sub_in), .pin_n(pin_n), .req(req)
	);

	always #20 clk = !clk;
	always @(posedge main_in) me++;
	always @(posedge sub_in) se++;
	// Tick is launched on the rising edge, so count it on the falling one
	always @(negedge clk) if (tick === 1'b1) tk++;

	function automatic logic [31:0] xs();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction : xs

	task automatic close_out();
		$display("comparisons %0d, mismatches %0d", tests_run, num_errors);
		if (num_errors == 0 && tests_run > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask : close_out

	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		tests_run++;
		if (got !== exp) begin
			num_errors++;
			$display("MISMATCH at %0t: value %h, expected %h", $time, got, exp);
		end
	endtask : chk

	// Edge counts cross the synchroniser, so a small lag is allowed
	task automatic chk_cnt(input int got, input int exp);
		tests_run++;
		if (got < exp - 2 || got > exp + 8) begin
			num_errors++;
			$display("MISMATCH at %0t: count %0d, expected %0d", $time, got, exp);
		end
	endtask : chk_cnt

	always @(posedge clk) begin
		cycles++;
		if (cycles == 95000) begin
			num_errors++;
			close_out();
		end
	end

	// =====================================================
	// Main sequence
	initial begin
		repeat (2) @(posedge clk);
		@(negedge clk);
		nrst = 1'b1;
		me = 0;
		chk(cpu_rst_n, 8'h00);
		chk(t3v, 8'hff);
		chk(t4v, 8'h07);
		while (!cpu_en) @(negedge clk);
		chk_cnt(me, 16 * 2048);
		chk(cpu_rst_n & flag3 & flag4, 8'h01);
		tk = 0;
		me = 0;
		repeat (200) @(negedge clk);
		chk_cnt(tk, me / 2);
		$display("done: power-on wait");
		for (int k = 0; k < 2; k++) begin
			line = int'(xs() % 8);
			if (line == 4 && k == 0)
				line = 0;
			t_stop = 1'b1;
			fclr = 1'b1;
			@(negedge clk);
			fclr = 1'b0;
			chk(flag3 | flag4, 8'h00);
			src = k ? 2'h3 : 2'h2;
			sub_en = k[0];
			drive_hi = k[0];
			ext_ser = k[0];
			wen = 8'h10 | (8'h01 << line);
			@(negedge clk);
			t_stop = 1'b0;
			repeat (2) @(negedge clk);
			halt = 1'b1;
			@(negedge clk);
			halt = 1'b0;
			@(negedge clk);
			chk(stop_m, 8'h01);
			chk(main_run | sub_run | cpu_en, 8'h00);
			chk(t3v, 8'hff);
			chk(t4v, 8'h07);
			chk(hold & tmr_halt & conv_halt, 8'h01);
			chk(ser_halt, 8'(k == 0));
			chk(t1h | t2h, 8'h00);
			chk(drv, 8'(drive_hi));
			chk(conv_halt, 8'h01);
			if (k == 0) begin
				far_side_model_i.raise(4);
				repeat (20) @(negedge clk);
				chk(stop_m, 8'h01);
			end
			far_side_model_i.raise(line);
			n = 0;
			while (wake_ack !== 1'b1 && n < 4) begin
				@(negedge clk);
				n++;
			end
			me = 0;
			se = 0;
			chk(wake_ack & cpu_rst_n, 8'h01);
			chk(sub_run, 8'(k));
			while (!cpu_en) @(negedge clk);
			chk_cnt(k ? se : me, 2 * 2048);
			chk(flag3 & flag4 & !hold, 8'h01);
			chk(sub_ok, 8'(k));
			src = 2'h0;
			$display("done: wake %0d on line %0d", k, line);
		end
		far_side_model_i.pin_reset(20);
		repeat (4) @(negedge clk);
		chk(cpu_rst_n, 8'h01);
		src = 2'h3;
		halt = 1'b1;
		@(negedge clk);
		halt = 1'b0;
		far_side_model_i.pin_reset(60);
		me = 0;
		repeat (4) @(negedge clk);
		chk(cpu_rst_n | stop_m | flag3 | flag4, 8'h00);
		chk(t4v, 8'h07);
		chk(main_run, 8'h01);
		repeat (300) @(negedge clk);
		chk(cpu_rst_n, 8'h00);
		chk_cnt(255 - int'(t3v), me / 16);
		$display("done: pin reset");
		close_out();
	end
endmodule : testbench
